// >>> common/fsp_pkg.sv
`default_nettype none
package fsp_pkg;
   // Bus geometry.
   localparam int ADDR_W      = 17;
   localparam int DATA_W      = 8;
   localparam int SECT_LSB    = 7;
   localparam int SECT_MSB    = 16;
   localparam int SECT_W      = SECT_MSB - SECT_LSB + 1;
   localparam int BYTE_W      = SECT_LSB;
   localparam int TOGGLE_BIT  = 6;
   localparam int POLL_BIT    = 7;
   // Clock and timing figures.
   localparam int CLK_NS      = 25;
   localparam int WP_NS       = 90;
   localparam int WPH_NS      = 100;
   localparam int AH_NS       = 50;
   localparam int ACC_NS      = 150;
   localparam int OEHP_NS     = 150;
   localparam int BLC_US      = 150;
   localparam int WC_MS       = 10;
   localparam int WP_CYC      = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC     = (WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int AH_CYC      = (AH_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int OEHP_CYC    = (OEHP_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLC_CYC     = (BLC_US * 1000) / CLK_NS;
   localparam int WC_CYC      = (WC_MS * 1000000) / CLK_NS;
   localparam int CNT_W       = 20;
   // Host sequencer states.
   typedef enum logic [2:0] {FSP_IDLE, FSP_WR_LOW, FSP_WR_HIGH, FSP_RD_LOW, FSP_RD_HIGH, FSP_DONE} fsp_state_t;
endpackage
`default_nettype wire

// >>> common/fsp_stream_if.sv
`default_nettype none
interface fsp_stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> verilog/fsp_skid_buf.sv
`default_nettype none
module fsp_skid_buf #(
   parameter int W = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   fsp_stream_if.snk in_s,
   fsp_stream_if.src out_s
);
   logic [W-1:0] mem_reg [2];
   logic [W-1:0] mem_next [2];
   logic         wp_reg, wp_next, rp_reg, rp_next;
   logic [1:0]   cnt_reg, cnt_next;
   logic         rdy_reg, rdy_next;
   logic         push, pop;

   // Two-entry buffer; ready stays low while both entries are full.
   always_comb begin
      in_s.ready  = rdy_reg;
      out_s.valid = (cnt_reg != 2'h0);
      out_s.data  = mem_reg[rp_reg];
      push        = in_s.valid && in_s.ready;
      pop         = out_s.valid && out_s.ready;
      mem_next    = mem_reg;
      wp_next     = wp_reg;
      rp_next     = rp_reg;
      cnt_next    = cnt_reg;
      if (push) begin
         mem_next[wp_reg] = in_s.data;
         wp_next          = ~wp_reg;
      end
      if (pop) begin
         rp_next = ~rp_reg;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'h1;
      end
      // Ready is registered so the upstream side sees a flip-flop, not a compare.
      rdy_next = (cnt_next != 2'h2);
   end

   // Registers the buffer state.
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         cnt_reg <= 2'h0;
         rdy_reg <= 1'b1;
         mem_reg <= '{default: '0};
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
         mem_reg <= mem_next;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/fsp_host.sv
`default_nettype none
module fsp_host #(
   parameter int BLC_CYC = fsp_pkg::BLC_CYC,
   parameter int WC_CYC  = fsp_pkg::WC_CYC
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        start,
   input  wire logic [fsp_pkg::SECT_W-1:0]  sector,
   input  wire logic                        byte_valid,
   output logic                             byte_ready,
   input  wire logic [fsp_pkg::DATA_W-1:0]  byte_data,
   input  wire logic                        byte_last,
   output logic                             busy,
   output logic                             done,
   output logic                             timeout,
   output logic [fsp_pkg::ADDR_W-1:0]       flash_addr,
   output logic                             flash_ce_n,
   output logic                             flash_oe_n,
   output logic                             flash_we_n,
   output logic [fsp_pkg::DATA_W-1:0]       flash_dq_out,
   output logic                             flash_dq_oe,
   input  wire logic [fsp_pkg::DATA_W-1:0]  flash_dq_in
);
   fsp_stream_if #(.W(fsp_pkg::DATA_W + 1)) up_s ();
   fsp_stream_if #(.W(fsp_pkg::DATA_W + 1)) dn_s ();

   fsp_pkg::fsp_state_t             st_reg, st_next;
   logic [fsp_pkg::CNT_W-1:0]       tmr_reg, tmr_next;
   logic [fsp_pkg::CNT_W-1:0]       wc_reg, wc_next;
   logic [fsp_pkg::BYTE_W-1:0]      idx_reg, idx_next;
   logic [fsp_pkg::SECT_W-1:0]      sect_reg, sect_next;
   logic [fsp_pkg::DATA_W-1:0]      last_reg, last_next;
   logic                            islast_reg, islast_next;
   logic                            havetog_reg, havetog_next;
   logic                            tog_reg, tog_next;
   logic [fsp_pkg::ADDR_W-1:0]      addr_reg, addr_next;
   logic                            ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next;
   logic [fsp_pkg::DATA_W-1:0]      dq_reg, dq_next;
   logic                            dqoe_reg, dqoe_next;
   logic                            busy_reg, busy_next, done_reg, done_next, to_reg, to_next;

   // Incoming bytes pass through a two-entry buffer so a stall drops nothing.
   assign up_s.valid = byte_valid;
   assign up_s.data  = {byte_last, byte_data};
   assign byte_ready = up_s.ready;

   fsp_skid_buf #(.W(fsp_pkg::DATA_W + 1)) u_buf (
      .clk   (clk),
      .rst   (rst),
      .in_s  (up_s),
      .out_s (dn_s)
   );

   // Sequencer: byte loads, then toggle polling until the line stops moving.
   always_comb begin
      st_next      = st_reg;
      tmr_next     = tmr_reg;
      wc_next      = wc_reg;
      idx_next     = idx_reg;
      sect_next    = sect_reg;
      last_next    = last_reg;
      islast_next  = islast_reg;
      havetog_next = havetog_reg;
      tog_next     = tog_reg;
      addr_next    = addr_reg;
      ce_next      = ce_reg;
      oe_next      = oe_reg;
      we_next      = we_reg;
      dq_next      = dq_reg;
      dqoe_next    = dqoe_reg;
      busy_next    = busy_reg;
      done_next    = 1'b0;
      to_next      = to_reg;
      dn_s.ready   = 1'b0;
      if (tmr_reg != '0) begin
         tmr_next = tmr_reg - 1'b1;
      end
      case (st_reg)
         fsp_pkg::FSP_IDLE: begin
            if (start) begin
               sect_next = sector;
               idx_next  = '0;
               busy_next = 1'b1;
               to_next   = 1'b0;
               tmr_next  = fsp_pkg::CNT_W'(BLC_CYC);
               st_next   = fsp_pkg::FSP_WR_HIGH;
            end
         end
         fsp_pkg::FSP_WR_HIGH: begin
            if (tmr_reg == '0) begin
               st_next  = fsp_pkg::FSP_RD_HIGH;
               tmr_next = fsp_pkg::CNT_W'(fsp_pkg::OEHP_CYC);
               wc_next  = fsp_pkg::CNT_W'(WC_CYC);
               havetog_next = 1'b0;
            end else if (tmr_reg <= fsp_pkg::CNT_W'(BLC_CYC - fsp_pkg::WPH_CYC) && dn_s.valid && !islast_reg) begin
               dn_s.ready  = 1'b1;
               // sector address held; byte index from idx_reg
               addr_next   = {sect_reg, idx_reg};
               dq_next     = dn_s.data[fsp_pkg::DATA_W-1:0];
               last_next   = dn_s.data[fsp_pkg::DATA_W-1:0];
               islast_next = dn_s.data[fsp_pkg::DATA_W];
               dqoe_next   = 1'b1;
               oe_next     = 1'b1;
               ce_next     = 1'b0;
               we_next     = 1'b0;
               tmr_next    = fsp_pkg::CNT_W'(fsp_pkg::WP_CYC);
               st_next     = fsp_pkg::FSP_WR_LOW;
            end
         end
         fsp_pkg::FSP_WR_LOW: begin
            if (tmr_reg == '0) begin
               we_next  = 1'b1;
               ce_next  = 1'b1;
               idx_next = idx_reg + 1'b1;
               // Last byte or full sector ends loading; window then lapses.
               if (islast_reg || idx_reg == '1) begin
                  islast_next = 1'b1;
               end
               tmr_next = fsp_pkg::CNT_W'(BLC_CYC);
               st_next  = fsp_pkg::FSP_WR_HIGH;
            end
         end
         fsp_pkg::FSP_RD_HIGH: begin
            dqoe_next = 1'b0;
            if (wc_reg != '0) begin
               wc_next = wc_reg - 1'b1;
            end
            if (tmr_reg == '0) begin
               addr_next = {sect_reg, idx_reg - 1'b1};
               // read pulse on ce and oe
               ce_next   = 1'b0;
               oe_next   = 1'b0;
               tmr_next  = fsp_pkg::CNT_W'(fsp_pkg::ACC_CYC);
               st_next   = fsp_pkg::FSP_RD_LOW;
            end
         end
         fsp_pkg::FSP_RD_LOW: begin
            if (wc_reg != '0) begin
               wc_next = wc_reg - 1'b1;
            end
            if (tmr_reg == '0) begin
               ce_next      = 1'b1;
               oe_next      = 1'b1;
               tog_next     = flash_dq_in[fsp_pkg::TOGGLE_BIT];
               havetog_next = 1'b1;
               tmr_next     = fsp_pkg::CNT_W'(fsp_pkg::OEHP_CYC);
               st_next      = fsp_pkg::FSP_RD_HIGH;
               // toggle must stop and bit 7 must match the last byte; else wait or time out
               if (havetog_reg && tog_reg == flash_dq_in[fsp_pkg::TOGGLE_BIT]
                   && flash_dq_in[fsp_pkg::POLL_BIT] == last_reg[fsp_pkg::POLL_BIT]) begin
                  st_next = fsp_pkg::FSP_DONE;
               end else if (wc_reg == '0) begin
                  to_next = 1'b1;
                  st_next = fsp_pkg::FSP_DONE;
               end
            end
         end
         fsp_pkg::FSP_DONE: begin
            busy_next   = 1'b0;
            done_next   = 1'b1;
            islast_next = 1'b0;
            st_next     = fsp_pkg::FSP_IDLE;
         end
         default: begin
            st_next = fsp_pkg::FSP_IDLE;
         end
      endcase
   end

   // Registers sequencer state and every pin.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg      <= fsp_pkg::FSP_IDLE;
         tmr_reg     <= '0;
         wc_reg      <= '0;
         idx_reg     <= '0;
         sect_reg    <= '0;
         last_reg    <= '0;
         islast_reg  <= 1'b0;
         havetog_reg <= 1'b0;
         tog_reg     <= 1'b0;
         addr_reg    <= '0;
         ce_reg      <= 1'b1;
         oe_reg      <= 1'b1;
         we_reg      <= 1'b1;
         dq_reg      <= '0;
         dqoe_reg    <= 1'b0;
         busy_reg    <= 1'b0;
         done_reg    <= 1'b0;
         to_reg      <= 1'b0;
      end else begin
         st_reg      <= st_next;
         tmr_reg     <= tmr_next;
         wc_reg      <= wc_next;
         idx_reg     <= idx_next;
         sect_reg    <= sect_next;
         last_reg    <= last_next;
         islast_reg  <= islast_next;
         havetog_reg <= havetog_next;
         tog_reg     <= tog_next;
         addr_reg    <= addr_next;
         ce_reg      <= ce_next;
         oe_reg      <= oe_next;
         we_reg      <= we_next;
         dq_reg      <= dq_next;
         dqoe_reg    <= dqoe_next;
         busy_reg    <= busy_next;
         done_reg    <= done_next;
         to_reg      <= to_next;
      end
   end

   // Pins and status come straight from registers.
   assign flash_addr   = addr_reg;
   assign flash_ce_n   = ce_reg;
   assign flash_oe_n   = oe_reg;
   assign flash_we_n   = we_reg;
   assign flash_dq_out = dq_reg;
   assign flash_dq_oe  = dqoe_reg;
   assign busy         = busy_reg;
   assign done         = done_reg;
   assign timeout      = to_reg;
endmodule
`default_nettype wire

// >>> verification/fsp_host_assertions.sv
`default_nettype none
module fsp_host_assertions #(parameter int BLC_CYC = 6000) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        start,
   input wire logic [9:0]  sector,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        timeout,
   input wire logic [16:0] flash_addr,
   input wire logic        flash_ce_n,
   input wire logic        flash_oe_n,
   input wire logic        flash_we_n,
   input wire logic [7:0]  flash_dq_out,
   input wire logic        flash_dq_oe,
   input wire logic [7:0]  flash_dq_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0]  sect_reg;
   logic [16:0] paddr_reg;
   logic [7:0]  wdat_reg;
   logic [7:0]  rd_reg;
   logic        rd_seen_reg;
   logic        wr_seen_reg;
   logic        prev6_reg;
   int          gap_reg;
   // Remembers the sector, last written byte, polling address and read samples.
   // The load gap is counted from the end of one write pulse to the start of the next.
   always_ff @(posedge clk) begin
      gap_reg <= $rose(flash_we_n) ? 0 : gap_reg + (gap_reg < 99999 ? 1 : 0);
      if (!flash_oe_n) rd_reg <= flash_dq_in;
      if ($fell(flash_we_n)) begin
         wdat_reg <= flash_dq_out;
         wr_seen_reg <= 1'h1;
      end
      if ($fell(flash_oe_n)) begin
         paddr_reg <= flash_addr;
         prev6_reg <= rd_reg[6];
         rd_seen_reg <= 1'h1;
      end
      if (rst || (start && !busy)) begin
         sect_reg <= sector;
         rd_seen_reg <= 1'h0;
         wr_seen_reg <= 1'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_oe_blocked: assert property (!flash_ce_n && !flash_we_n |-> flash_oe_n) else $error("oe low in write");
   a_sector_held: assert property ($fell(flash_we_n) |-> flash_addr[16:7] == sect_reg) else $error("sector moved");
   a_load_gap: assert property ($fell(flash_we_n) && wr_seen_reg |-> gap_reg < BLC_CYC) else $error("gap");
   a_read_pulse: assert property ($fell(flash_oe_n) |-> !flash_ce_n && flash_we_n && !flash_dq_oe) else $error("rd");
   a_poll_fixed: assert property ($fell(flash_oe_n) && rd_seen_reg |-> flash_addr == paddr_reg) else $error("addr");
   a_no_load_poll: assert property (rd_seen_reg |-> !$fell(flash_we_n)) else $error("write while polling");
   a_done_stop: assert property (done && !timeout |-> rd_reg[6] == prev6_reg && rd_reg[7] == wdat_reg[7])
      else $error("done");
   a_done_pulse: assert property (done |-> !busy ##1 !done) else $error("done pulse");
   cover property (done);
   cover property ($fell(flash_oe_n) && rd_seen_reg);
   cover property ($fell(flash_we_n) && wr_seen_reg);
endmodule
bind fsp_host fsp_host_assertions #(.BLC_CYC(BLC_CYC)) u_chk (.clk, .rst, .start, .sector, .busy, .done, .timeout,
   .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe, .flash_dq_in);
`default_nettype wire

// >>> verification/fsp_flash_model.sv
`default_nettype none
module fsp_flash_model #(parameter int WIN = 40) (
   input wire logic        clk,
   input wire logic [16:0] addr,
   input wire logic        ce_n,
   input wire logic        oe_n,
   input wire logic        we_n,
   input wire logic [7:0]  dq_out,
   input wire logic        dq_oe,
   input wire logic [19:0] prog_cyc,
   output logic [7:0]      dq_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0]   mem [128];
   logic [127:0] ld = '0;
   logic [7:0]   last;
   logic [7:0]   hold = 8'h00;
   logic [9:0]   sect;
   logic         wr_q = 1'h0;
   logic         rd_q = 1'h0;
   logic         tog = 1'h0;
   int           win = 0;
   int           prog = 0;
   wire logic    wr = !ce_n && !we_n;
   wire logic    rd = !ce_n && !oe_n && !dq_oe;
   // status while busy, released bus shows the inverse of its last value.
   always_comb begin
      if (dq_oe) dq_in = dq_out;
      else if (!rd) dq_in = hold;
      else if (prog > 0) dq_in = {~last[7], tog, last[5:0]};
      else dq_in = mem[addr[6:0]];
   end
   // Latches byte loads, runs the load window and the program cycle.
   always @(posedge clk) begin
      wr_q <= wr;
      rd_q <= rd;
      if (rd) hold <= ~dq_in;
      // each read pulse during programming flips the toggle line.
      if (rd_q && !rd && prog > 0) tog <= ~tog;
      if (wr && !wr_q && prog == 0) begin
         mem[addr[6:0]] <= dq_out;
         ld[addr[6:0]] <= 1'h1;
         last <= dq_out;
         sect <= addr[16:7];
         win <= WIN;
      end else if (win > 0) begin
         win <= win - 1;
         if (win == 1) prog <= int'(prog_cyc);
      end
      if (prog > 0) prog <= prog - 1;
      if (prog == 1) begin
         for (int i = 0; i < 128; i++) if (!ld[i]) mem[i] <= ~mem[i];
         ld <= '0;
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'h0, rst = 1'h1, start = 1'h0, byte_valid = 1'h0, byte_last = 1'h0;
   logic [9:0]  sector = '0;
   logic [7:0]  byte_data = '0;
   logic [19:0] prog_cyc = 20'h12c;
   logic        byte_ready, busy, done, timeout, ce_n, oe_n, we_n, dq_oe;
   logic [16:0] addr;
   logic [7:0]  dq_out, dq_in;
   int          n_mismatch = 0, checks = 0;
   fsp_host #(.BLC_CYC(50), .WC_CYC(2000)) DUT (.clk, .rst, .start, .sector, .byte_valid, .byte_ready,
      .byte_data, .byte_last, .busy, .done, .timeout, .flash_addr(addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
   fsp_flash_model #(.WIN(40)) flash (.clk, .addr, .ce_n, .oe_n, .we_n, .dq_out, .dq_oe, .prog_cyc, .dq_in);
   // Clock generator.
   initial forever #12.5 clk = ~clk;
   task automatic tick();
      @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [7:0] pat(input int i);
      return 8'(i * 37 + 90);
   endfunction
   task automatic wait_flag(input int lim, input logic tmo);
      int k;
      for (k = 0; k < lim; k++) begin
         tick();
         if (tmo ? timeout : done) break;
      end
      if (k == lim) begin
         chk(k, 0);
         summarize();
      end
   endtask
   task automatic send(input int n, input logic lst, input int gap, input logic again);
      logic r;
      for (int i = 0; i < n; i++) begin
         if (!byte_valid) byte_valid = 1'h1;
         byte_data = pat(i);
         byte_last = lst && i == n - 1;
         r = 1'h0;
         // Ready is read between edges; the edge crossed next is the one that takes the byte.
         for (int k = 0; k < 5000 && !r; k++) begin
            r = byte_ready;
            tick();
         end
         if (!r) begin
            chk(r, 1);
            summarize();
         end
         if (gap > 0 || i == n - 1) byte_valid = 1'h0;
         if (again && i == 0) begin
            start = 1'h1;
            sector = ~sector;
            tick();
            start = 1'h0;
         end
         repeat (gap) tick();
      end
   endtask
   task automatic t_prog(input logic [9:0] s, input int n, input logic lst, input int gap, input logic again,
                         input logic [19:0] pc);
      prog_cyc = pc;
      start = 1'h1;
      sector = s;
      tick();
      start = 1'h0;
      chk(busy, 1);
      send(n, lst, gap, again);
      wait_flag(20000, 0);
      chk(timeout, 0);
      tick();
      chk(busy, 0);
      chk(flash.sect, s);
      for (int i = 0; i < n; i++) chk(flash.mem[i], pat(i));
      $display("test program sector %h bytes %0d ended", s, n);
   endtask
   // Holds reset for five edges and checks the idle pin levels after release.
   task automatic t_reset();
      repeat (5) tick();
      rst = 1'h0;
      chk({ce_n, oe_n, we_n, dq_oe, busy, done, timeout}, 7'h70);
      chk(addr, 0);
      $display("test reset ended");
   endtask
   // Programming that outlasts the write cycle limit must end in a timeout; done is still low in the cycle timeout rises.
   task automatic t_timeout(input logic [9:0] s, input logic [19:0] pc);
      prog_cyc = pc;
      start = 1'h1;
      sector = s;
      tick();
      start = 1'h0;
      send(1, 1, 0, 0);
      wait_flag(10000, 1);
      chk(timeout, 1);
      chk(done, 0);
      $display("test timeout ended");
   endtask
   // Main sequence.
   initial begin
      t_reset();
      t_prog(10'h000, 4, 1, 3, 0, 20'h12c);
      t_prog(10'h3ff, 128, 0, 0, 0, 20'h5dc);
      t_prog(10'h155, 2, 1, 2, 1, 20'h1);
      t_timeout(10'h2aa, 20'h1388);
      summarize();
   end
endmodule
`default_nettype wire
